// *** tb/ctrl_partner.sv ***
// controller model on the ready pass-through side
`timescale 1ns/1ps
module ctrl_partner (
    // requests from the bench
    input  wire logic ackNext,
    input  wire logic holdReq,
    input  wire logic bussed,
    // to the block
    output logic      readyAckPassthruInN,
    output logic      readyAckHold,
    output logic      readyAckOutEnableN
);
    // =========================================================
    // ready drive
    // pass-through keeps enable low; ready launched a cycle early
    assign readyAckOutEnableN  = bussed;
    // bussed option ties pass-through high, ready shared on the line
    assign readyAckPassthruInN = bussed ? 1'b1 : !ackNext;
    assign readyAckHold        = holdReq;
endmodule

// *** tb/tag_ram_ready_merge_tb.sv ***
// self-checking bench for the ready merge and standby block
`timescale 1ns/1ps
module tag_ram_ready_merge_tb;
    // =========================================================
    // signals
    localparam int AW = 4;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, tagIn, tagOut;
    logic [31:0] pwdata, prdata, rd;
    logic [AW-1:0] cacheAddr;
    tag_ram_pkg::status_bits_t statusIn, statusOut;
    logic tagOutEn, statusOutEn, toeN, tweN, sweN, csFirstN, csSecond, ttBit, pdN;
    logic ackNext, holdReq, bussed, rdyInN, hold, rdyOeN, rdyN, rdyEn, matchOut, matchEn;
    logic err, generic;
    int n_errors, comparisons, seed;
    logic [11:0] tagMem [16];
    logic [2:0] statMem [16];
    logic [2:0] codes [4];

    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end

    tag_ram_ready_merge #(.ADDR_W(AW)) tag_ram_ready_merge_inst (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cacheAddr(cacheAddr), .tagIn(tagIn), .tagOut(tagOut), .tagOutEn(tagOutEn),
        .statusIn(statusIn), .statusOut(statusOut), .statusOutEn(statusOutEn),
        .tagOutputEnableN(toeN), .tagWriteEnableN(tweN), .statusWriteEnableN(sweN),
        .chipSelectFirstN(csFirstN), .chipSelectSecond(csSecond), .transferTypeBit(ttBit),
        .powerDownN(pdN), .readyAckHold(hold), .readyAckPassthruInN(rdyInN),
        .readyAckOutEnableN(rdyOeN), .readyAckOutN(rdyN), .readyAckOutEn(rdyEn),
        .matchOut(matchOut), .matchOutEn(matchEn));

    ctrl_partner ctrl_partner_inst (.ackNext(ackNext), .holdReq(holdReq), .bussed(bussed),
        .readyAckPassthruInN(rdyInN), .readyAckHold(hold), .readyAckOutEnableN(rdyOeN));

    // =========================================================
    // checking and ending
    task automatic chk_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        end_sim();
    end

    // =========================================================
    // bus and array tasks, entered right after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask

    // controller owns every status change
    task automatic wr_entry(input int a, input logic [11:0] t, input logic [2:0] s);
        cacheAddr <= a[AW-1:0];
        tagIn <= t;
        statusIn <= s;
        tweN <= 0;
        sweN <= 0;
        @(posedge clk);
        tweN <= 1;
        sweN <= 1;
        tagMem[a] = t;
        statMem[a] = s;
        @(posedge clk);
    endtask

    // one random lookup, checked after the sampling edge
    task automatic step();
        logic [31:0] r;
        logic [AW-1:0] ad;
        logic [11:0] tg;
        logic sel, pw, mat, intr, pt;
        r = $random(seed);
        ad = r[19:16];
        tg = r[13] ? tagMem[ad] : 12'(r[31:20]);
        sel = !(r[0] & r[1]) && !(r[2] & r[3]);
        pw = !(r[10] & r[11]);
        pt = (r[14] & r[15]) ? 1'b1 : !r[9];
        csFirstN <= r[0] & r[1];
        csSecond <= !(r[2] & r[3]);
        toeN <= !(r[4] & r[5]);
        ttBit <= r[6];
        holdReq <= r[7] & r[8];
        ackNext <= r[9];
        pdN <= pw;
        bussed <= r[14] & r[15];
        cacheAddr <= ad;
        tagIn <= tg;
        mat = sel && pw && !(r[4] & r[5]) && tg == tagMem[ad] && (generic || statMem[ad][0]);
        intr = mat && !(r[7] & r[8]) && !(!generic && !r[6] && statMem[ad][2]);
        @(posedge clk);
        #1;
        chk_bit(rdyN, !intr && pt, "ready");
        chk_bit(rdyEn, sel && pw && !(r[14] & r[15]), "ready en");
        chk_bit(matchEn, sel && pw, "match en");
        chk_bit(tagOutEn, sel && pw && (r[4] & r[5]), "tag en");
        chk_bit(statusOutEn, sel && pw, "status en");
        chk_word(32'(tagOut), 32'(tagMem[ad]), "tag out");
        chk_word(32'(statusOut), 32'(statMem[ad]), "status out");
        if (sel && pw)
            chk_bit(matchOut, mat, "match");
        @(posedge clk);
    endtask

    // =========================================================
    // main sequence
    initial begin
        seed = 32'h4bb1;
        n_errors = 0;
        comparisons = 0;
        generic = 0;
        codes = '{tag_ram_pkg::MESI_SHARED, tag_ram_pkg::MESI_EXCLUSIVE,
                  tag_ram_pkg::MESI_MODIFIED, 3'h4};
        sys_rst = 1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cacheAddr, tagIn, statusIn, ttBit, holdReq, ackNext, bussed} = '0;
        {toeN, tweN, sweN, csSecond, pdN} = 5'h1f;
        csFirstN = 0;
        repeat (4) @(posedge clk);
        sys_rst <= 0;
        #1;
        chk_bit(rdyN, 1'b1, "reset ready");
        chk_bit(matchOut, 1'b0, "reset match");
        for (int i = 0; i < 16; i++)
            statMem[i] = 3'h0;
        @(posedge clk);
        apb(1'b0, tag_ram_pkg::CTRL_OFFSET, 32'h0);
        chk_word(rd, 32'h0, "ctrl reset");
        apb(1'b0, 12'h00c, 32'h0);
        chk_bit(err, 1'b1, "unmapped err");
        chk_word(rd, 32'h0, "unmapped read");
        for (int i = 0; i < 16; i++)
            wr_entry(i, 12'($random(seed)), codes[i % 4]);
        // pass-through pulse: sampled at an edge, shown the cycle after
        toeN <= 0;
        ackNext <= 1;
        #1;
        chk_bit(rdyN, 1'b1, "pulse early");
        @(posedge clk);
        ackNext <= 0;
        #1;
        chk_bit(rdyN, 1'b0, "pulse low");
        @(posedge clk);
        #1;
        chk_bit(rdyN, 1'b1, "pulse end");
        @(posedge clk);
        repeat (400) step();
        apb(1'b1, tag_ram_pkg::CTRL_OFFSET, 32'h1);
        generic = 1;
        apb(1'b0, tag_ram_pkg::CTRL_OFFSET, 32'h0);
        chk_word(rd, 32'h1, "ctrl readback");
        repeat (400) step();
        // hit counter: cleared outside match mode, then three hit cycles
        toeN <= 0;
        apb(1'b1, tag_ram_pkg::HITCNT_OFFSET, 32'h0);
        csFirstN <= 0;
        csSecond <= 1;
        pdN <= 1;
        holdReq <= 0;
        cacheAddr <= '0;
        tagIn <= tagMem[0];
        toeN <= 1;
        repeat (3) @(posedge clk);
        toeN <= 0;
        apb(1'b0, tag_ram_pkg::HITCNT_OFFSET, 32'h0);
        chk_word(rd, 32'h3, "hit count");
        // software standby keeps the outputs off
        csFirstN <= 0;
        csSecond <= 1;
        pdN <= 1;
        apb(1'b1, tag_ram_pkg::CTRL_OFFSET, 32'h2);
        apb(1'b0, tag_ram_pkg::STATE_OFFSET, 32'h0);
        chk_bit(rd[tag_ram_pkg::ST_POWER_DOWN_N_POS], 1'b1, "standby state");
        chk_bit(matchEn, 1'b0, "standby en");
        apb(1'b1, tag_ram_pkg::CTRL_OFFSET, 32'h0);
        end_sim();
    end
endmodule

// *** verilog/tag_ram_pkg.sv ***
// shared constants and types for the tag sram ready/standby block
package tag_ram_pkg;

    // =========================================================
    // field widths
    localparam int TAG_W  = 12;
    localparam int STAT_W = 3;

    // =========================================================
    // status field layout (dedicated mode)
    localparam int VALID_POS = 0;
    localparam int DIRTY_POS = 1;
    localparam int WT_POS    = 2;

    typedef struct packed {
        logic writeThrough;
        logic dirty;
        logic valid;
    } status_bits_t;

    // suggested coherency encodings, for controller use
    localparam status_bits_t MESI_SHARED    = 3'h5;
    localparam status_bits_t MESI_EXCLUSIVE = 3'h1;
    localparam status_bits_t MESI_MODIFIED  = 3'h3;
    localparam status_bits_t STATUS_CLEARED = 3'h0;

    // =========================================================
    // apb register map
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] STATE_OFFSET  = 12'h004;
    localparam logic [11:0] HITCNT_OFFSET = 12'h008;

    localparam int CTRL_GENERIC_POS  = 0;
    localparam int CTRL_FORCEPD_POS  = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    localparam int ST_MATCH_POS  = 0;
    localparam int ST_READY_POS  = 1;
    localparam int ST_POWER_DOWN_N_POS  = 2;
    localparam int ST_STATUS_LSB = 4;

    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

// *** verilog/tag_ram_ready_merge.sv ***
// tag sram ready/acknowledge merge, match output and standby control
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module tag_ram_ready_merge #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // address and tag bus
    input  wire logic [ADDR_W-1:0]             cacheAddr,
    input  wire logic [tag_ram_pkg::TAG_W-1:0] tagIn,
    output logic      [tag_ram_pkg::TAG_W-1:0] tagOut,
    output logic                               tagOutEn,
    // status bus
    input  wire tag_ram_pkg::status_bits_t     statusIn,
    output tag_ram_pkg::status_bits_t          statusOut,
    output logic                               statusOutEn,
    // controls
    input  wire logic                          tagOutputEnableN,
    input  wire logic                          tagWriteEnableN,
    input  wire logic                          statusWriteEnableN,
    input  wire logic                          chipSelectFirstN,
    input  wire logic                          chipSelectSecond,
    input  wire logic                          transferTypeBit,
    input  wire logic                          powerDownN,
    // ready merge
    input  wire logic                          readyAckHold,
    input  wire logic                          readyAckPassthruInN,
    input  wire logic                          readyAckOutEnableN,
    output logic                               readyAckOutN,
    output logic                               readyAckOutEn,
    // match
    output logic                               matchOut,
    output logic                               matchOutEn
);

    // =========================================================
    // apb register file
    tag_ram_pkg::apb_req_t req;
    logic [1:0]  ctrl;
    logic [1:0]  next_ctrl;
    logic [31:0] hitCount;
    logic [31:0] next_hitCount;
    logic [31:0] next_prdata;
    logic        mapped;
    logic        accessEdge;

    assign req = '{psel, penable, pwrite, paddr, pwdata};

    function automatic logic isMapped(input logic [11:0] a);
        return (a == tag_ram_pkg::CTRL_OFFSET) || (a == tag_ram_pkg::STATE_OFFSET)
            || (a == tag_ram_pkg::HITCNT_OFFSET);
    endfunction

    // zero wait state slave: every access completes in its first access cycle
    assign pready     = 1'b1;
    assign accessEdge = req.psel && req.penable;
    assign mapped     = isMapped(req.paddr);
    assign pslverr    = accessEdge && !mapped;

    // =========================================================
    // core datapath
    logic                          selected;
    logic                          powered;
    logic                          matchMode;
    logic                          compareHit;
    logic                          isWrite;
    logic                          genericMode;
    logic                          intReadyN;
    logic [tag_ram_pkg::TAG_W-1:0] storedTag;
    tag_ram_pkg::status_bits_t     storedStatus;
    logic                          tagWrite;
    logic                          statusWrite;
    logic [tag_ram_pkg::TAG_W-1:0] tagWriteData;

    logic                          readyOutN;
    logic                          next_readyOutN;
    logic                          matchReg;
    logic                          next_matchReg;
    logic [tag_ram_pkg::TAG_W-1:0] tagReg;
    logic [tag_ram_pkg::TAG_W-1:0] next_tagReg;
    tag_ram_pkg::status_bits_t     statReg;
    tag_ram_pkg::status_bits_t     next_statReg;

    assign genericMode = ctrl[tag_ram_pkg::CTRL_GENERIC_POS];
    // software standby request acts like the pin held low
    assign powered     = powerDownN && !ctrl[tag_ram_pkg::CTRL_FORCEPD_POS];
    assign selected    = !chipSelectFirstN && chipSelectSecond;
    assign matchMode   = tagOutputEnableN && tagWriteEnableN;
    assign compareHit  = (storedTag == tagIn);
    // transfer type low marks a processor write; tie high to disable the check
    assign isWrite     = !transferTypeBit;

    // no writes while powered down, so stored contents survive standby
    assign tagWrite     = selected && powered && !tagWriteEnableN;
    assign statusWrite  = selected && powered && !statusWriteEnableN;
    // tag write with output enable low writes back the stored tag
    assign tagWriteData = tagOutputEnableN ? tagIn : storedTag;

    tag_status_store #(
        .ADDR_W(ADDR_W)
    ) store (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .addr       (cacheAddr),
        .tagWrite   (tagWrite),
        .tagData    (tagWriteData),
        .statusWrite(statusWrite),
        .statusData (statusIn),
        .tagRead    (storedTag),
        .statusRead (storedStatus)
    );

    always_comb begin
        // internal ready is active low; hold and out-of-match force it high
        intReadyN = 1'b1;
        if (selected && powered && matchMode && compareHit && !readyAckHold) begin
            if (genericMode) begin
                intReadyN = 1'b0;
            end else if (storedStatus.valid && !(isWrite && storedStatus.writeThrough)) begin
                intReadyN = 1'b0;
            end
        end
        // hold is not applied here: the pass-through term always reaches the pin
        next_readyOutN = intReadyN & readyAckPassthruInN;
        next_matchReg  = matchMode && compareHit && (genericMode || storedStatus.valid);
        next_tagReg    = storedTag;
        next_statReg   = storedStatus;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readyOutN <= 1'b1;
            matchReg  <= 1'b0;
            tagReg    <= '0;
            statReg   <= tag_ram_pkg::STATUS_CLEARED;
        end else begin
            readyOutN <= next_readyOutN;
            matchReg  <= next_matchReg;
            tagReg    <= next_tagReg;
            statReg   <= next_statReg;
        end
    end

    // enables follow the pins directly so standby exit is immediate
    assign readyAckOutEn = selected && powered && !readyAckOutEnableN;
    assign matchOutEn    = selected && powered;
    assign tagOutEn      = selected && powered && !tagOutputEnableN && tagWriteEnableN;
    assign statusOutEn   = selected && powered;
    assign readyAckOutN  = readyOutN;
    assign matchOut      = matchReg;
    assign tagOut        = tagReg;
    assign statusOut     = statReg;

    // =========================================================
    // register next values
    always_comb begin
        next_ctrl     = ctrl;
        next_hitCount = hitCount;
        next_prdata   = prdata;
        if (!intReadyN) begin
            next_hitCount = hitCount + 32'h0000_0001;
        end
        if (accessEdge && req.pwrite && req.paddr == tag_ram_pkg::CTRL_OFFSET) begin
            next_ctrl = req.pwdata[1:0];
        end
        // writing the counter clears it; a hit in the same cycle is still counted, leaving one
        if (accessEdge && req.pwrite && req.paddr == tag_ram_pkg::HITCNT_OFFSET) begin
            next_hitCount = intReadyN ? 32'h0000_0000 : 32'h0000_0001;
        end
        if (req.psel && !req.penable && !req.pwrite) begin
            next_prdata = tag_ram_pkg::READ_ZERO;
            unique case (1'b1)
                req.paddr == tag_ram_pkg::CTRL_OFFSET: begin
                    next_prdata[1:0] = ctrl;
                end
                req.paddr == tag_ram_pkg::STATE_OFFSET: begin
                    next_prdata[tag_ram_pkg::ST_MATCH_POS] = matchReg;
                    next_prdata[tag_ram_pkg::ST_READY_POS] = !readyOutN;
                    next_prdata[tag_ram_pkg::ST_POWER_DOWN_N_POS] = !powered;
                    next_prdata[tag_ram_pkg::ST_STATUS_LSB +: tag_ram_pkg::STAT_W] = statReg;
                end
                req.paddr == tag_ram_pkg::HITCNT_OFFSET: begin
                    next_prdata = hitCount;
                end
                default: begin
                    next_prdata = tag_ram_pkg::READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl     <= tag_ram_pkg::CTRL_RESET;
            hitCount <= 32'h0000_0000;
            prdata   <= 32'h0000_0000;
        end else begin
            ctrl     <= next_ctrl;
            hitCount <= next_hitCount;
            prdata   <= next_prdata;
        end
    end

    // =========================================================
    // assertions
    a_passthru_merge: assert property (@(posedge clk) disable iff (sys_rst)
        !readyAckPassthruInN |=> !readyAckOutN)
        else $error("pass-through low did not pull ready low");

    a_hold_no_block: assert property (@(posedge clk) disable iff (sys_rst)
        (readyAckHold && !readyAckPassthruInN) |=> !readyAckOutN)
        else $error("hold blocked the pass-through ready");

    a_float_deselect: assert property (@(posedge clk) disable iff (sys_rst)
        (!selected || readyAckOutEnableN) |-> !readyAckOutEn && !(tagOutEn && !selected))
        else $error("ready driven while deselected or disabled");

    a_high_outside_match: assert property (@(posedge clk) disable iff (sys_rst)
        (!matchMode && readyAckPassthruInN) |=> readyAckOutN && !matchOut)
        else $error("ready or match active outside match mode");

    a_power_down_n_floats: assert property (@(posedge clk) disable iff (sys_rst)
        !powerDownN |-> !(readyAckOutEn || matchOutEn || tagOutEn || statusOutEn))
        else $error("output driven during power-down");

    a_power_down_n_retains: assert property (@(posedge clk) disable iff (sys_rst)
        (!powerDownN ##1 $stable(cacheAddr)) |-> $stable(storedStatus) && $stable(storedTag))
        else $error("stored data changed during power-down");

    a_power_down_n_no_write: assert property (@(posedge clk) disable iff (sys_rst)
        !powerDownN |-> !tagWrite && !statusWrite)
        else $error("write accepted during power-down");

    a_wake_ready_en: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(powerDownN) && selected && !readyAckOutEnableN && !ctrl[tag_ram_pkg::CTRL_FORCEPD_POS])
        |-> readyAckOutEn)
        else $error("ready enable not back right after power-down release");

    a_wake_quick: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(powerDownN) && selected && !ctrl[tag_ram_pkg::CTRL_FORCEPD_POS]) |-> matchOutEn)
        else $error("outputs not back right after power-down release");

    a_wt_write_block: assert property (@(posedge clk) disable iff (sys_rst)
        (!genericMode && isWrite && storedStatus.writeThrough && readyAckPassthruInN)
        |=> readyAckOutN)
        else $error("ready on write to write-through line");

    a_invalid_no_match: assert property (@(posedge clk) disable iff (sys_rst)
        (!genericMode && !storedStatus.valid) |=> !matchOut)
        else $error("match on invalid entry in dedicated mode");

    a_hold_forces_high: assert property (@(posedge clk) disable iff (sys_rst)
        (readyAckHold && readyAckPassthruInN) |=> readyAckOutN)
        else $error("internal ready not held off");

    a_ready_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
        (readyAckPassthruInN && intReadyN) |=> readyAckOutN ##1 readyAckOutN == $past(next_readyOutN))
        else $error("ready output not one cycle behind its inputs");

    c_internal_hit: cover property (@(posedge clk) disable iff (sys_rst)
        !intReadyN ##1 !readyAckOutN && readyAckOutEn);
    c_passthru_only: cover property (@(posedge clk) disable iff (sys_rst)
        intReadyN && !readyAckPassthruInN ##1 !readyAckOutN);
    c_power_down_n_cycle: cover property (@(posedge clk) disable iff (sys_rst)
        !powerDownN ##1 !powerDownN ##1 powerDownN);
    c_wt_blocked: cover property (@(posedge clk) disable iff (sys_rst)
        matchMode && compareHit && isWrite && storedStatus.writeThrough && storedStatus.valid);

endmodule

// *** verilog/tag_status_store.sv ***
// tag and status storage array with retained contents
`timescale 1ns/1ps
module tag_status_store #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // access
    input  wire logic [ADDR_W-1:0]             addr,
    input  wire logic                          tagWrite,
    input  wire logic [tag_ram_pkg::TAG_W-1:0] tagData,
    input  wire logic                          statusWrite,
    input  wire tag_ram_pkg::status_bits_t     statusData,
    // read
    output logic      [tag_ram_pkg::TAG_W-1:0] tagRead,
    output tag_ram_pkg::status_bits_t          statusRead
);

    localparam int DEPTH = 1 << ADDR_W;

    // =========================================================
    // storage
    logic [tag_ram_pkg::TAG_W-1:0] tagMem [DEPTH];
    tag_ram_pkg::status_bits_t     statMem [DEPTH];

    // no reset on tags: in dedicated mode contents only matter once valid is set
    always_ff @(posedge clk) begin
        if (tagWrite) begin
            tagMem[addr] <= tagData;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                statMem[i] <= tag_ram_pkg::STATUS_CLEARED;
            end
        end else if (statusWrite) begin
            statMem[addr] <= statusData;
        end
    end

    assign tagRead    = tagMem[addr];
    assign statusRead = statMem[addr];

endmodule
